// >>> include/hbl_pkg.sv
// Constants and types shared by the fault, lock and diagnostic register bank.
package hbl_pkg;

  // Register addresses on the serial link.
  localparam logic [4:0] HBL_ADDR_LOCK_DRIVE = 5'h04;
  localparam logic [4:0] HBL_ADDR_DIAG_REG   = 5'h05;

  // Field positions in the fault-clear, lock and drive register.
  localparam int HBL_FAULT_CLEAR_BIT = 7;
  localparam int HBL_KEY_MSB         = 6;
  localparam int HBL_KEY_LSB         = 4;
  localparam int HBL_HALF_A_OFF_BIT  = 3;
  localparam int HBL_HALF_B_OFF_BIT  = 2;
  localparam int HBL_SW_INPUT_A_BIT  = 1;
  localparam int HBL_SW_INPUT_B_BIT  = 0;

  // Field positions in the diagnostic and regulation register.
  localparam int HBL_RESERVED_BIT    = 7;
  localparam int HBL_OL_RUN_BIT      = 6;
  localparam int HBL_OL_DELAY_BIT    = 5;
  localparam int HBL_OL_ACTIVE_BIT   = 4;
  localparam int HBL_LEVEL_MSB       = 3;
  localparam int HBL_LEVEL_LSB       = 2;
  localparam int HBL_REG_DIS_MSB     = 1;
  localparam int HBL_REG_DIS_LSB     = 0;

  // Values after reset, key patterns and the drive mode in which the half-bridge off bits act.
  localparam logic [2:0] HBL_KEY_LOCK      = 3'h3;
  localparam logic [2:0] HBL_KEY_UNLOCK    = 3'h4;
  localparam logic [2:0] HBL_KEY_RESET     = 3'h4;
  localparam logic [1:0] HBL_LEVEL_RESET   = 2'h2;
  localparam logic [1:0] HBL_REG_DIS_RESET = 2'h0;
  localparam logic [1:0] HBL_MODE_INDEP    = 2'h2;

  // Serial frame layout: bit 14 read flag, bits 13..9 address, bits 7..0 data.
  localparam int HBL_FRAME_BITS = 16;
  localparam int HBL_READ_BIT   = 14;
  localparam int HBL_ADDR_MSB   = 13;
  localparam int HBL_ADDR_LSB   = 9;
  localparam int HBL_HEAD_BITS  = 8;

  // Open-load diagnostic delays.
  localparam int  HBL_CLK_PERIOD_NS   = 10;
  localparam int  HBL_OL_SHORT_US     = 300;
  localparam real HBL_OL_LONG_MS      = 1.2;
  localparam int  HBL_OL_SHORT_CYCLES = (HBL_OL_SHORT_US * 1000) / HBL_CLK_PERIOD_NS;
  localparam int  HBL_OL_LONG_CYCLES  = int'(HBL_OL_LONG_MS * 1000000.0) / HBL_CLK_PERIOD_NS;
  localparam int  HBL_OL_CNT_W        = 17;

  typedef enum logic [1:0] {
    HBL_OL_IDLE = 2'b00,
    HBL_OL_WAIT = 2'b01,
    HBL_OL_DONE = 2'b10
  } hbl_ol_state_t;

endpackage

// >>> include/hbl_reg_if.sv
// Register access carrier between the serial link and the register bank.
`timescale 1ns/100ps
interface hbl_reg_if;
  logic       wr_stb;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport link (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// >>> hw/hbl_spi_link.sv
// Serial peripheral slave that turns 16-bit frames into register accesses.
`timescale 1ns/100ps
module hbl_spi_link
  import hbl_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // Serial pins
  input  wire logic i_spi_sclk,
  input  wire logic i_spi_cs_n,
  input  wire logic i_spi_sdi,
  output logic      o_spi_sdo,
  output logic      o_spi_sdo_oe_n,
  // Register side
  hbl_reg_if.link   bus
);

  logic        sclk_meta;
  logic [1:0]  sclk_sync;
  logic        cs_meta;
  logic [1:0]  cs_sync;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [4:0]  bit_cnt;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_end;

  // The first stage of each synchroniser feeds only the second.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 2'h0;
      cs_meta   <= 1'b1;
      cs_sync   <= 2'h3;
    end else begin
      sclk_meta <= i_spi_sclk;
      sclk_sync <= {sclk_sync[0], sclk_meta};
      cs_meta   <= i_spi_cs_n;
      cs_sync   <= {cs_sync[0], cs_meta};
    end
  end

  // Data is sampled from its own pair so it lines up with the clock edge seen here.
  logic sdi_meta;
  logic sdi_sync;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      sdi_meta <= i_spi_sdi;
      sdi_sync <= sdi_meta;
    end
  end

  assign sclk_rise = sclk_sync[0] & ~sclk_sync[1] & ~cs_sync[0];
  assign sclk_fall = ~sclk_sync[0] & sclk_sync[1] & ~cs_sync[0];
  assign cs_end    = cs_sync[0] & ~cs_sync[1];

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_shift <= 16'h0000;
      bit_cnt  <= 5'h00;
    end else if (cs_sync[0]) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      rx_shift <= {rx_shift[14:0], sdi_sync};
      // Counting one past a full frame marks an overlong frame so it is never committed.
      if (bit_cnt != 5'(HBL_FRAME_BITS + 1)) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Address is held from the header so the bank can prepare read data early.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.addr   <= 5'h00;
      bus.wdata  <= 8'h00;
      bus.wr_stb <= 1'b0;
    end else begin
      bus.wr_stb <= 1'b0;
      if (sclk_rise && bit_cnt == 5'(HBL_HEAD_BITS - 1)) begin
        bus.addr <= rx_shift[4:0];
      end
      if (cs_end && bit_cnt == 5'(HBL_FRAME_BITS) && !rx_shift[HBL_READ_BIT]) begin
        bus.addr   <= rx_shift[HBL_ADDR_MSB:HBL_ADDR_LSB];
        bus.wdata  <= rx_shift[7:0];
        bus.wr_stb <= 1'b1;
      end
    end
  end

  // Output shifts on the falling edge; the data byte is loaded after the header.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_shift       <= 16'h0000;
      o_spi_sdo      <= 1'b0;
      o_spi_sdo_oe_n <= 1'b1;
    end else begin
      o_spi_sdo_oe_n <= cs_sync[0];
      if (cs_sync[0]) begin
        tx_shift  <= 16'h0000;
        o_spi_sdo <= 1'b0;
      end else if (sclk_fall) begin
        if (bit_cnt == 5'(HBL_HEAD_BITS)) begin
          o_spi_sdo <= bus.rdata[7];
          tx_shift  <= {bus.rdata[6:0], 9'h000};
        end else begin
          o_spi_sdo <= tx_shift[15];
          tx_shift  <= {tx_shift[14:0], 1'b0};
        end
      end
    end
  end

endmodule // hbl_spi_link

// >>> hw/hbl_fault_lock_regs.sv
// Upper control registers: fault clear, lock key, drive override, open-load and regulation.
`timescale 1ns/100ps
module hbl_fault_lock_regs
  import hbl_pkg::*;
#(
  parameter int OL_SHORT_CYCLES = HBL_OL_SHORT_CYCLES,
  parameter int OL_LONG_CYCLES  = HBL_OL_LONG_CYCLES
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // Serial pins
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sdi,
  output logic            o_spi_sdo,
  output logic            o_spi_sdo_oe_n,
  // From the first control register and device state
  input  wire logic [1:0] i_drive_mode,
  input  wire logic       i_drive_source_sel,
  input  wire logic       i_standby,
  // External drive pins
  input  wire logic       i_pin_input_a,
  input  wire logic       i_pin_input_b,
  // Fault and lock control
  output logic            o_fault_clear,
  output logic            o_settings_locked,
  // Power stage control
  output logic            o_half_bridge_a_hiz,
  output logic            o_half_bridge_b_hiz,
  output logic            o_drive_a,
  output logic            o_drive_b,
  // Diagnostics and regulation
  output logic            o_openload_busy,
  output logic            o_openload_sample,
  output logic            o_openload_active_en,
  output logic [1:0]      o_current_level,
  output logic            o_regulation_off_a,
  output logic            o_regulation_off_b
);

  hbl_reg_if bus ();

  hbl_spi_link u_link (
    .i_ref_clk      (i_ref_clk),
    .i_resetn       (i_resetn),
    .i_spi_sclk     (i_spi_sclk),
    .i_spi_cs_n     (i_spi_cs_n),
    .i_spi_sdi      (i_spi_sdi),
    .o_spi_sdo      (o_spi_sdo),
    .o_spi_sdo_oe_n (o_spi_sdo_oe_n),
    .bus            (bus.link)
  );

  // Stored fields.
  logic                    fault_clear_cmd;
  logic [2:0]              lock_key;
  logic                    locked;
  logic                    half_bridge_a_off;
  logic                    half_bridge_b_off;
  logic                    sw_drive_input_a;
  logic                    sw_drive_input_b;
  logic                    reserved_bit;
  logic                    standby_openload_run;
  logic                    openload_delay_sel;
  logic                    active_openload_enable;
  logic [1:0]              regulation_current_level;
  logic [1:0]              regulation_disable_sel;
  logic                    pin_a_meta;
  logic                    pin_a_sync;
  logic                    pin_b_meta;
  logic                    pin_b_sync;
  hbl_ol_state_t           ol_state;
  hbl_ol_state_t           next_ol_state;
  logic [HBL_OL_CNT_W-1:0] ol_count;
  logic                    wr_lock_reg;
  logic                    wr_diag_reg;
  logic                    ol_start;

  function automatic logic [HBL_OL_CNT_W-1:0] ol_limit(input logic long_sel);
    ol_limit = long_sel ? HBL_OL_CNT_W'(OL_LONG_CYCLES - 1) : HBL_OL_CNT_W'(OL_SHORT_CYCLES - 1);
  endfunction

  assign wr_lock_reg = bus.wr_stb && bus.addr == HBL_ADDR_LOCK_DRIVE;
  assign wr_diag_reg = bus.wr_stb && bus.addr == HBL_ADDR_DIAG_REG;
  assign ol_start    = wr_diag_reg && !locked && bus.wdata[HBL_OL_RUN_BIT] && i_standby;

  // Drive pins come from outside the clock domain.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_a_meta <= 1'b0;
      pin_a_sync <= 1'b0;
      pin_b_meta <= 1'b0;
      pin_b_sync <= 1'b0;
    end else begin
      pin_a_meta <= i_pin_input_a;
      pin_a_sync <= pin_a_meta;
      pin_b_meta <= i_pin_input_b;
      pin_b_sync <= pin_b_meta;
    end
  end

  // Fault clear reads back as one only for the cycle of its pulse.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_clear_cmd <= 1'b0;
    end else begin
      fault_clear_cmd <= wr_lock_reg && bus.wdata[HBL_FAULT_CLEAR_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fault_clear <= 1'b0;
    end else begin
      o_fault_clear <= wr_lock_reg && bus.wdata[HBL_FAULT_CLEAR_BIT];
    end
  end

  // Key field is always writable; only the two patterns change the lock state.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_key <= HBL_KEY_RESET;
      locked   <= 1'b0;
    end else if (wr_lock_reg) begin
      lock_key <= bus.wdata[HBL_KEY_MSB:HBL_KEY_LSB];
      if (bus.wdata[HBL_KEY_MSB:HBL_KEY_LSB] == HBL_KEY_LOCK) begin
        locked <= 1'b1;
      end else if (bus.wdata[HBL_KEY_MSB:HBL_KEY_LSB] == HBL_KEY_UNLOCK) begin
        locked <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_settings_locked <= 1'b0;
    end else begin
      o_settings_locked <= locked;
    end
  end

  // Protected drive bits keep their value while locked.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half_bridge_a_off <= 1'b0;
      half_bridge_b_off <= 1'b0;
      sw_drive_input_a  <= 1'b0;
      sw_drive_input_b  <= 1'b0;
    end else if (wr_lock_reg && !locked) begin
      half_bridge_a_off <= bus.wdata[HBL_HALF_A_OFF_BIT];
      half_bridge_b_off <= bus.wdata[HBL_HALF_B_OFF_BIT];
      sw_drive_input_a  <= bus.wdata[HBL_SW_INPUT_A_BIT];
      sw_drive_input_b  <= bus.wdata[HBL_SW_INPUT_B_BIT];
    end
  end

  // Diagnostic and regulation settings, protected the same way.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reserved_bit             <= 1'b0;
      openload_delay_sel       <= 1'b0;
      active_openload_enable   <= 1'b0;
      regulation_current_level <= HBL_LEVEL_RESET;
      regulation_disable_sel   <= HBL_REG_DIS_RESET;
    end else if (wr_diag_reg && !locked) begin
      reserved_bit             <= bus.wdata[HBL_RESERVED_BIT];
      openload_delay_sel       <= bus.wdata[HBL_OL_DELAY_BIT];
      active_openload_enable   <= bus.wdata[HBL_OL_ACTIVE_BIT];
      regulation_current_level <= bus.wdata[HBL_LEVEL_MSB:HBL_LEVEL_LSB];
      regulation_disable_sel   <= bus.wdata[HBL_REG_DIS_MSB:HBL_REG_DIS_LSB];
    end
  end

  // Open-load sequencer. A start in the finishing cycle wins and restarts the test.
  always_comb begin
    next_ol_state = ol_state;
    case (ol_state)
      HBL_OL_IDLE: begin
        if (ol_start) begin
          next_ol_state = HBL_OL_WAIT;
        end
      end
      HBL_OL_WAIT: begin
        if (ol_count == ol_limit(openload_delay_sel)) begin
          next_ol_state = HBL_OL_DONE;
        end
      end
      HBL_OL_DONE: begin
        next_ol_state = ol_start ? HBL_OL_WAIT : HBL_OL_IDLE;
      end
      default: begin
        next_ol_state = HBL_OL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_state <= HBL_OL_IDLE;
    end else begin
      ol_state <= next_ol_state;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_count <= '0;
    end else if (ol_state == HBL_OL_WAIT && next_ol_state == HBL_OL_WAIT) begin
      ol_count <= ol_count + HBL_OL_CNT_W'(1);
    end else begin
      ol_count <= '0;
    end
  end

  // The run bit mirrors the test in progress so software can poll for completion.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      standby_openload_run <= 1'b0;
    end else begin
      standby_openload_run <= (next_ol_state == HBL_OL_WAIT);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_openload_busy   <= 1'b0;
      o_openload_sample <= 1'b0;
    end else begin
      o_openload_busy   <= (next_ol_state == HBL_OL_WAIT);
      o_openload_sample <= (next_ol_state == HBL_OL_DONE);
    end
  end

  // Power stage controls. Pins add two cycles of latency against register bits.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_half_bridge_a_hiz <= 1'b0;
      o_half_bridge_b_hiz <= 1'b0;
      o_drive_a           <= 1'b0;
      o_drive_b           <= 1'b0;
    end else begin
      o_half_bridge_a_hiz <= (i_drive_mode == HBL_MODE_INDEP) && half_bridge_a_off;
      o_half_bridge_b_hiz <= (i_drive_mode == HBL_MODE_INDEP) && half_bridge_b_off;
      o_drive_a           <= i_drive_source_sel ? sw_drive_input_a : pin_a_sync;
      o_drive_b           <= i_drive_source_sel ? sw_drive_input_b : pin_b_sync;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_openload_active_en <= 1'b0;
      o_current_level      <= HBL_LEVEL_RESET;
      o_regulation_off_a   <= 1'b0;
      o_regulation_off_b   <= 1'b0;
    end else begin
      o_openload_active_en <= active_openload_enable;
      o_current_level      <= regulation_current_level;
      o_regulation_off_a   <= regulation_disable_sel[0];
      o_regulation_off_b   <= regulation_disable_sel[1];
    end
  end

  // Read data is registered; the link takes it on the next serial falling edge after the address.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.rdata <= 8'h00;
    end else begin
      case (bus.addr)
        HBL_ADDR_LOCK_DRIVE: begin
          bus.rdata <= {fault_clear_cmd, lock_key, half_bridge_a_off, half_bridge_b_off,
                        sw_drive_input_a, sw_drive_input_b};
        end
        HBL_ADDR_DIAG_REG: begin
          bus.rdata <= {reserved_bit, standby_openload_run, openload_delay_sel, active_openload_enable,
                        regulation_current_level, regulation_disable_sel};
        end
        default: begin
          bus.rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule // hbl_fault_lock_regs

// >>> verification/hbl_spi_host.sv
// Serial bus host model that frames register reads and writes on the link pins.
`timescale 1ns/100ps
module hbl_spi_host (
  // Clock
  input  wire logic i_ref_clk,
  // Serial pins
  input  wire logic i_spi_sdo,
  output logic      o_spi_sclk,
  output logic      o_spi_cs_n,
  output logic      o_spi_sdi
);
  // Phases are kept long so that the device's pin synchroniser settles before sampling.
  localparam int HALF = 6;

  initial begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_sdi  = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {1'b0, rd, a, 1'b0, d};
    q = 8'h00;
    @(posedge i_ref_clk);
    o_spi_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_spi_sdi <= f[15 - i];
      if (i >= 8) begin
        q[15 - i] = i_spi_sdo;
      end
      repeat (HALF) @(posedge i_ref_clk);
      o_spi_sclk <= 1'b1;
      repeat (HALF) @(posedge i_ref_clk);
      o_spi_sclk <= 1'b0;
      repeat (HALF) @(posedge i_ref_clk);
    end
    o_spi_cs_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    o_spi_sdi <= ~f[0];
    repeat (10) @(posedge i_ref_clk);
  endtask
endmodule // hbl_spi_host

// >>> verification/hbl_chk.sv
// Concurrent checks on the ports of the fault, lock and diagnostic register bank.
`timescale 1ns/100ps
module hbl_chk
  import hbl_pkg::*;
#(
  parameter int OL_SHORT_CYCLES = HBL_OL_SHORT_CYCLES,
  parameter int OL_LONG_CYCLES  = HBL_OL_LONG_CYCLES
) (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_resetn,
  // Watched inputs
  input wire logic [1:0] i_drive_mode,
  input wire logic       i_standby,
  // Watched outputs
  input wire logic       o_fault_clear,
  input wire logic       o_settings_locked,
  input wire logic       o_half_bridge_a_hiz,
  input wire logic       o_half_bridge_b_hiz,
  input wire logic       o_openload_busy,
  input wire logic       o_openload_sample,
  input wire logic       o_openload_active_en,
  input wire logic [1:0] o_current_level,
  input wire logic       o_regulation_off_a,
  input wire logic       o_regulation_off_b
);
  int busy_cnt;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // A counter that never clears shows up as an overlong test.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= o_openload_busy ? busy_cnt + 1 : 0;
    end
  end

  fault_pulse_a: assert property (o_fault_clear |=> !o_fault_clear) else $error("fault clear too long");
  hiz_a_mode_a: assert property (o_half_bridge_a_hiz |-> $past(i_drive_mode) == HBL_MODE_INDEP) else $error("a hiz mode");
  hiz_b_mode_a: assert property (o_half_bridge_b_hiz |-> $past(i_drive_mode) == HBL_MODE_INDEP) else $error("b hiz mode");
  ol_start_a: assert property ($rose(o_openload_busy) |-> $past(i_standby)) else $error("test outside standby");
  ol_sample_a: assert property (o_openload_sample |=> !o_openload_sample && !o_openload_busy) else $error("test end");
  ol_done_a: assert property ($fell(o_openload_busy) |-> o_openload_sample || $past(o_openload_sample)) else $error("no sample");
  ol_len_a: assert property (busy_cnt <= OL_LONG_CYCLES + 2) else $error("test too long");
  lock_hold_a: assert property (o_settings_locked && $past(o_settings_locked) |->
    $stable({o_openload_active_en, o_current_level, o_regulation_off_a, o_regulation_off_b})) else $error("locked change");
endmodule // hbl_chk

bind hbl_fault_lock_regs hbl_chk #(.OL_SHORT_CYCLES(OL_SHORT_CYCLES), .OL_LONG_CYCLES(OL_LONG_CYCLES)) i_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_drive_mode(i_drive_mode), .i_standby(i_standby),
  .o_fault_clear(o_fault_clear), .o_settings_locked(o_settings_locked),
  .o_half_bridge_a_hiz(o_half_bridge_a_hiz), .o_half_bridge_b_hiz(o_half_bridge_b_hiz),
  .o_openload_busy(o_openload_busy), .o_openload_sample(o_openload_sample),
  .o_openload_active_en(o_openload_active_en), .o_current_level(o_current_level),
  .o_regulation_off_a(o_regulation_off_a), .o_regulation_off_b(o_regulation_off_b)
);

// >>> verification/testbench.sv
// Self-checking bench for the fault, lock and diagnostic register bank.
`timescale 1ns/100ps
module testbench;
  import hbl_pkg::*;
  localparam int OL_S = 300;
  localparam int OL_L = 1200;
  logic       i_ref_clk, i_resetn, sclk, cs_n, sdi, sdo, sdo_oe_n, src_sel, standby, pin_a, pin_b;
  logic [1:0] mode, level;
  logic       fclr, locked, hiz_a, hiz_b, drv_a, drv_b, ol_busy, ol_sample, ol_act, roff_a, roff_b;
  logic [7:0] q;
  int         error_cnt, checked, m4, m5, key, lk, fclr_cnt, busy_len, n;

  hbl_fault_lock_regs #(.OL_SHORT_CYCLES(OL_S), .OL_LONG_CYCLES(OL_L)) i_dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe_n(sdo_oe_n), .i_drive_mode(mode), .i_drive_source_sel(src_sel),
    .i_standby(standby), .i_pin_input_a(pin_a), .i_pin_input_b(pin_b), .o_fault_clear(fclr),
    .o_settings_locked(locked), .o_half_bridge_a_hiz(hiz_a), .o_half_bridge_b_hiz(hiz_b),
    .o_drive_a(drv_a), .o_drive_b(drv_b), .o_openload_busy(ol_busy), .o_openload_sample(ol_sample),
    .o_openload_active_en(ol_act), .o_current_level(level), .o_regulation_off_a(roff_a),
    .o_regulation_off_b(roff_b)
  );
  hbl_spi_host i_host (.i_ref_clk(i_ref_clk), .i_spi_sdo(sdo), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_sdi(sdi));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (fclr === 1'b1) fclr_cnt++;
    if (ol_busy === 1'b1) busy_len++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Model: protected fields are taken only while unlocked; the run bit only in standby.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, q);
    if (a == HBL_ADDR_LOCK_DRIVE) begin
      if (lk == 0) m4 = d[3:0];
      key = d[6:4];
      if (key == 3) lk = 1;
      if (key == 4) lk = 0;
    end else if (a == HBL_ADDR_DIAG_REG && lk == 0) begin
      m5 = d & (standby ? 8'hff : 8'hbf);
    end
  endtask

  task automatic rd(input logic [4:0] a);
    logic [7:0] e;
    e = a == HBL_ADDR_LOCK_DRIVE ? 8'(key * 16 + m4) : (a == HBL_ADDR_DIAG_REG ? 8'(m5) : 8'h00);
    i_host.xfer(1'b1, a, 8'h00, q);
    chk({1'b0, q}, {1'b0, e}, "read");
  endtask

  task automatic outs();
    logic [8:0] e;
    e[8] = mode == HBL_MODE_INDEP && m4[3];
    e[7] = mode == HBL_MODE_INDEP && m4[2];
    e[6] = src_sel ? m4[1] : pin_a;
    e[5] = src_sel ? m4[0] : pin_b;
    e[4:0] = 5'(m5);
    chk({hiz_a, hiz_b, drv_a, drv_b, ol_act, level, roff_b, roff_a}, e, "outputs");
  endtask

  initial begin
    repeat (60000) @(posedge i_ref_clk);
    error_cnt++;
    $display("BAD at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    i_resetn = 1'b0;
    mode = 2'h0;
    src_sel = 1'b0;
    standby = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    void'($urandom(91679));
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    m4 = 0;
    key = 4;
    lk = 0;
    m5 = 8'h08;
    repeat (4) @(posedge i_ref_clk);
    chk(9'(locked), 9'h0, "lock after reset");
    chk(9'(sdo_oe_n), 9'h1, "data out released");
    rd(HBL_ADDR_LOCK_DRIVE);
    rd(HBL_ADDR_DIAG_REG);
    outs();
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      @(posedge i_ref_clk);
      mode <= 2'(i);
      src_sel <= 1'($urandom);
      pin_a <= 1'($urandom);
      pin_b <= 1'($urandom);
      wr(HBL_ADDR_LOCK_DRIVE, {1'b0, 3'h4, 4'($urandom)});
      wr(HBL_ADDR_DIAG_REG, {1'($urandom), 1'b0, 2'($urandom), 4'(i)});
      rd(HBL_ADDR_LOCK_DRIVE);
      rd(HBL_ADDR_DIAG_REG);
      outs();
    end
    $display("test fields done");
    n = fclr_cnt;
    wr(HBL_ADDR_LOCK_DRIVE, {1'b1, 3'(key), 4'(m4)});
    chk(9'(fclr_cnt - n), 9'h1, "clear pulses");
    rd(HBL_ADDR_LOCK_DRIVE);
    wr(HBL_ADDR_LOCK_DRIVE, {1'b0, 3'h3, 4'(m4)});
    chk(9'(locked), 9'h1, "locked");
    wr(HBL_ADDR_LOCK_DRIVE, {1'b0, 3'h3, ~4'(m4)});
    wr(HBL_ADDR_DIAG_REG, 8'h5f);
    n = fclr_cnt;
    wr(HBL_ADDR_LOCK_DRIVE, {1'b1, 3'h3, 4'(m4)});
    chk(9'(fclr_cnt - n), 9'h1, "clear while locked");
    rd(HBL_ADDR_LOCK_DRIVE);
    rd(HBL_ADDR_DIAG_REG);
    outs();
    wr(HBL_ADDR_LOCK_DRIVE, {1'b0, 3'h4, 4'(m4)});
    chk(9'(locked), 9'h0, "unlocked");
    wr(HBL_ADDR_DIAG_REG, 8'h1b);
    rd(HBL_ADDR_DIAG_REG);
    wr(5'h07, 8'hff);
    rd(5'h07);
    rd(HBL_ADDR_LOCK_DRIVE);
    $display("test lock done");
    busy_len = 0;
    wr(HBL_ADDR_DIAG_REG, 8'h48);
    rd(HBL_ADDR_DIAG_REG);
    chk(9'(busy_len), 9'h0, "test outside standby");
    @(posedge i_ref_clk);
    standby <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      busy_len = 0;
      wr(HBL_ADDR_DIAG_REG, {2'b01, 1'(k), 5'h08});
      rd(HBL_ADDR_DIAG_REG);
      for (int t = 0; t < 2000 && ol_busy !== 1'b0; t++) @(posedge i_ref_clk);
      m5 = m5 & 8'hbf;
      rd(HBL_ADDR_DIAG_REG);
      n = k ? OL_L : OL_S;
      chk(9'(busy_len >= n && busy_len <= n + 1), 9'h1, "test length");
    end
    $display("test open load done");
    final_report();
  end
endmodule // testbench
